// file: hw/ddid_decoder.sv
// ddid_decoder: digital input terminal decoder with wishbone registers
// assumes terminals are asynchronous pins; one 40 MHz clock, sync reset
//
// Overview of operation
// - each terminal has its own function code
// - code zero terminal produces no command
// - reset clears alarm on rising edge
// - inverted coast low switches output off
// - coast-reset low coasts, falling edge resets
// - inverted quick stop low uses quick ramp
// - dc brake low, suppressed if time/voltage zero
// - inverted stop low ramps to standstill
// - start high runs, low stops
// - latched start needs 14 ms pulse
// - reversing inverts direction, off in closed loop
// - start-reversing starts, reverses unless start high, not closed loop
// - cw-only and ccw-only restricted starts
// - fixed speed override, blocked by coast, qstop, dc
// - freeze reference held, changed by steps
// - freeze output frequency held, changed by steps
// - fifth terminal pulse ref/fb codes refused with pulse output
// - encoder codes only on pulse terminals, paired
// - 14 ms pulses step speed, down wins
// - ramp2 low first pair, high second
// - preset msb and lsb form index
// - catch-up adds, slow-down subtracts, slow wins
`timescale 1ns/1ps
`default_nettype none
module ddid_decoder #(
  parameter int unsigned MIN_PULSE = ddid_pkg::MIN_PULSE_CYC // 14 ms in cycles
) (
  input  wire logic        clk_i,        // 40 MHz control clock
  input  wire logic        rst_i,        // synchronous reset, active high
  input  wire logic [4:0]  term_i,       // terminal levels, asynchronous
  input  wire logic        wb_cyc_i,     // wishbone cycle
  input  wire logic        wb_stb_i,     // wishbone strobe
  input  wire logic        wb_we_i,      // wishbone write enable
  input  wire logic [7:0]  wb_adr_i,     // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,     // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,     // wishbone write data
  output logic [31:0]      wb_dat_o,     // wishbone read data
  output logic             wb_ack_o,     // wishbone acknowledge
  output ddid_pkg::ddid_cmd_s cmd_o,     // decoded drive commands
  output logic             alarm_clr_o,  // one-cycle alarm reset pulse
  output logic             step_up_o,    // one-cycle +0.1 step pulse
  output logic             step_dn_o     // one-cycle -0.1 step pulse
);
  localparam int unsigned CW = $clog2(MIN_PULSE + 1); // pulse counter width

  // synchroniser and edge state
  logic [4:0] sync1_reg;                 // first stage, read only by second
  logic [4:0] sync2_reg;                 // stable level
  logic [4:0] prev_reg;                  // level one cycle back
  logic [5:0] sel_reg [5];               // function selects
  logic [3:0] cfg_reg;                   // configuration bits
  logic       latch_run_reg;             // latched start state
  logic [CW-1:0] ls_cnt_reg;             // latched start high width
  logic [15:0] step_cnt_reg;             // net step count since reset

  // two-flop synchroniser and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      prev_reg  <= 5'h00;
    end else begin
      sync1_reg <= term_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // whether a code is legal for a terminal, given the current config
  function automatic logic code_ok(input int unsigned t, input logic [5:0] c,
                                   input logic pulse_out);
    logic ok;
    ok = 1'b0;
    if (c <= ddid_pkg::FN_SPD_DN || (c >= ddid_pkg::FN_CATCH && c <= ddid_pkg::FN_PRE_ON)
        || (c >= ddid_pkg::FN_SETUP_LSB && c <= ddid_pkg::FN_RST_START))
      ok = 1'b1;
    if (c == ddid_pkg::FN_PSTOP_N || c == ddid_pkg::FN_PSTARTSTOP)
      ok = (t < 2);
    if (c == ddid_pkg::FN_PULSE_REF || c == ddid_pkg::FN_PULSE_FB)
      ok = (t == ddid_pkg::PULSE_TERM_B && !pulse_out) || t == ddid_pkg::PULSE_TERM_A;
    if (c == ddid_pkg::FN_PULSE_IN)
      ok = (t == ddid_pkg::PULSE_TERM_B);
    if (c >= ddid_pkg::FN_ENC_REF && c <= ddid_pkg::FN_ENC_IN)
      ok = (t == ddid_pkg::PULSE_TERM_A || t == ddid_pkg::PULSE_TERM_B);
    return ok;
  endfunction : code_ok

  // wishbone decode
  logic        wb_req;                   // new request this cycle
  logic [2:0]  wb_idx;                   // word index
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_idx = wb_adr_i[4:2];

  // acknowledge one cycle after the request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else       wb_ack_o <= wb_req;
  end

  // function-select registers, illegal writes leave the old code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg[0] <= ddid_pkg::SEL_RST_0;
      sel_reg[1] <= ddid_pkg::SEL_RST_1;
      sel_reg[2] <= ddid_pkg::SEL_RST_2;
      sel_reg[3] <= ddid_pkg::SEL_RST_3;
      sel_reg[4] <= ddid_pkg::SEL_RST_4;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i[7:5] == 3'h0) begin
      for (int t = 0; t < 5; t++) begin
        if (wb_idx == 3'(t) && code_ok(t, wb_dat_i[5:0], cfg_reg[ddid_pkg::CFG_PULSE_OUT]))
          sel_reg[t] <= wb_dat_i[5:0];
      end
    end
  end

  // configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i)
      cfg_reg <= ddid_pkg::CFG_RST;
    else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ddid_pkg::OFS_CFG)
      cfg_reg <= wb_dat_i[3:0];
  end

  // per-function level and edge gathering
  logic [4:0] lvl;                       // stable levels
  logic [4:0] rise;                      // rising edges
  logic [4:0] fall;                      // falling edges
  assign lvl  = sync2_reg;
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  logic f_coast, f_qstop, f_dc, f_stop, f_start, f_rev, f_srev, f_cw, f_ccw;
  logic f_fix, f_frz_r, f_frz_o, f_up, f_dn, f_catch, f_slow, f_r2;
  logic f_plsb, f_pmsb, f_pon, f_slsb, f_smsb, f_pref, f_pfb, f_enc;
  logic f_rst_ev, f_ls_lvl, f_rs_start;

  // decode each terminal by its own code; code zero matches nothing
  always_comb begin
    {f_coast, f_qstop, f_dc, f_stop, f_start, f_rev, f_srev, f_cw, f_ccw} = '0;
    {f_fix, f_frz_r, f_frz_o, f_up, f_dn, f_catch, f_slow, f_r2} = '0;
    {f_plsb, f_pmsb, f_pon, f_slsb, f_smsb, f_pref, f_pfb, f_enc} = '0;
    {f_rst_ev, f_ls_lvl, f_rs_start} = '0;
    for (int t = 0; t < 5; t++) begin
      unique case (sel_reg[t])
        ddid_pkg::FN_RESET:      f_rst_ev |= rise[t];
        ddid_pkg::FN_COAST_N:    f_coast  |= !lvl[t];
        ddid_pkg::FN_RUNOUT_CLR: begin
          f_coast  |= !lvl[t];
          f_rst_ev |= fall[t];
        end
        ddid_pkg::FN_QSTOP_N:    f_qstop  |= !lvl[t];
        ddid_pkg::FN_DCHALT_N:   f_dc     |= !lvl[t];
        ddid_pkg::FN_STOP_N, ddid_pkg::FN_PSTOP_N: f_stop |= !lvl[t];
        ddid_pkg::FN_START, ddid_pkg::FN_PSTARTSTOP: f_start |= lvl[t];
        ddid_pkg::FN_LSTART:     f_ls_lvl |= lvl[t];
        ddid_pkg::FN_REV:        f_rev    |= lvl[t];
        ddid_pkg::FN_START_REV:  f_srev   |= lvl[t];
        ddid_pkg::FN_START_CW:   f_cw     |= lvl[t];
        ddid_pkg::FN_START_CCW:  f_ccw    |= lvl[t];
        ddid_pkg::FN_FIXSPD:     f_fix    |= lvl[t];
        ddid_pkg::FN_FRZ_REF:    f_frz_r  |= lvl[t];
        ddid_pkg::FN_FRZ_OUT:    f_frz_o  |= lvl[t];
        ddid_pkg::FN_SPD_UP:     f_up     |= lvl[t];
        ddid_pkg::FN_SPD_DN:     f_dn     |= lvl[t];
        ddid_pkg::FN_CATCH:      f_catch  |= lvl[t];
        ddid_pkg::FN_SLOW:       f_slow   |= lvl[t];
        ddid_pkg::FN_RAMP2:      f_r2     |= lvl[t];
        ddid_pkg::FN_PRE_LSB:    f_plsb   |= lvl[t];
        ddid_pkg::FN_PRE_MSB:    f_pmsb   |= lvl[t];
        ddid_pkg::FN_PRE_ON:     f_pon    |= lvl[t];
        ddid_pkg::FN_SETUP_LSB:  f_slsb   |= lvl[t];
        ddid_pkg::FN_SETUP_MSB:  f_smsb   |= lvl[t];
        ddid_pkg::FN_RST_START: begin
          f_rs_start |= lvl[t];
          f_rst_ev   |= rise[t];
        end
        ddid_pkg::FN_PULSE_REF:  f_pref   |= 1'b1;
        ddid_pkg::FN_PULSE_FB:   f_pfb    |= 1'b1;
        ddid_pkg::FN_ENC_REF, ddid_pkg::FN_ENC_FB, ddid_pkg::FN_ENC_IN: f_enc |= 1'b1;
        default: ;                       // no function, pulse input, unused codes
      endcase
    end
  end

  // halt conditions
  logic dc_active;                       // dc braking allowed and requested
  logic halt_any;                        // any stopping command
  logic closed;                          // closed-loop regulation
  assign closed    = cfg_reg[ddid_pkg::CFG_CLOSED_LOOP];
  assign dc_active = f_dc && cfg_reg[ddid_pkg::CFG_DC_TIME_NZ]
                     && cfg_reg[ddid_pkg::CFG_DC_VOLT_NZ];
  assign halt_any  = f_coast || f_qstop || dc_active || f_stop;

  // latched start: high width counted, held until a stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_cnt_reg    <= '0;
      latch_run_reg <= 1'b0;
    end else begin
      if (!f_ls_lvl)
        ls_cnt_reg <= '0;
      else if (ls_cnt_reg != CW'(MIN_PULSE))
        ls_cnt_reg <= ls_cnt_reg + 1'b1;
      if (halt_any)
        latch_run_reg <= 1'b0;
      else if (f_ls_lvl && ls_cnt_reg == CW'(MIN_PULSE - 1))
        latch_run_reg <= 1'b1;
    end
  end

  // speed step pulse qualifier: 14 ms high after a 14 ms low gap
  logic          stp_active;             // freeze mode enables stepping
  logic          stp_lvl;                // combined step input high
  logic          stp_dir_dn;             // down wins when both high
  logic [CW-1:0] hi_cnt_reg;             // high width
  logic [CW-1:0] lo_cnt_reg;             // low width
  logic          armed_reg;              // low gap has been seen
  logic          dn_seen_reg;            // down was high during pulse
  assign stp_active = f_frz_r || f_frz_o;
  assign stp_lvl    = f_up || f_dn;
  assign stp_dir_dn = f_dn;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_cnt_reg  <= '0;
      lo_cnt_reg  <= '0;
      armed_reg   <= 1'b1;
      dn_seen_reg <= 1'b0;
      step_up_o   <= 1'b0;
      step_dn_o   <= 1'b0;
    end else begin
      step_up_o <= 1'b0;
      step_dn_o <= 1'b0;
      if (stp_lvl) begin
        lo_cnt_reg <= '0;
        if (hi_cnt_reg != CW'(MIN_PULSE)) hi_cnt_reg <= hi_cnt_reg + 1'b1;
        dn_seen_reg <= dn_seen_reg | stp_dir_dn;
      end else begin
        if (hi_cnt_reg == CW'(MIN_PULSE) && armed_reg && stp_active) begin
          step_up_o <= !dn_seen_reg;
          step_dn_o <= dn_seen_reg;
        end
        if (hi_cnt_reg != '0) armed_reg <= 1'b0;
        else if (lo_cnt_reg == CW'(MIN_PULSE - 1)) armed_reg <= 1'b1;
        hi_cnt_reg  <= '0;
        dn_seen_reg <= 1'b0;
        if (lo_cnt_reg != CW'(MIN_PULSE)) lo_cnt_reg <= lo_cnt_reg + 1'b1;
      end
    end
  end

  // net step count, visible to software
  always_ff @(posedge clk_i) begin
    if (rst_i) step_cnt_reg <= 16'h0000;
    else if (step_up_o) step_cnt_reg <= step_cnt_reg + 16'h0001;
    else if (step_dn_o) step_cnt_reg <= step_cnt_reg - 16'h0001;
  end

  // registered command outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_o       <= '0;
      alarm_clr_o <= 1'b0;
    end else begin
      alarm_clr_o         <= f_rst_ev;
      cmd_o.coast         <= f_coast;
      cmd_o.quick_stop    <= f_qstop;
      cmd_o.dc_brake      <= dc_active;
      cmd_o.ramp_stop     <= f_stop;
      cmd_o.run           <= !halt_any && (f_start || latch_run_reg || f_cw || f_ccw
                             || f_rs_start || (f_srev && !closed));
      cmd_o.reverse       <= !closed && (f_rev || (f_srev && !f_start));
      cmd_o.dir_cw_only   <= f_cw;
      cmd_o.dir_ccw_only  <= f_ccw;
      cmd_o.fixed_speed   <= f_fix && !(f_coast || f_qstop || dc_active);
      cmd_o.freeze_ref    <= f_frz_r;
      cmd_o.freeze_out    <= f_frz_o;
      cmd_o.ramp2         <= f_r2;
      cmd_o.preset_idx    <= {f_pmsb, f_plsb};
      cmd_o.preset_on     <= f_pon;
      cmd_o.catch_up      <= f_catch && !f_slow;
      cmd_o.slow_down     <= f_slow;
      cmd_o.setup_idx     <= {f_smsb, f_slsb};
      cmd_o.pulse_ref     <= f_pref;
      cmd_o.pulse_fb      <= f_pfb;
      cmd_o.enc_sel       <= f_enc && (sel_reg[ddid_pkg::PULSE_TERM_A]
                             == sel_reg[ddid_pkg::PULSE_TERM_B]);
    end
  end

  // read data, registered alongside ack; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_dat_o <= 32'h0000_0000;
    else if (wb_req) begin
      wb_dat_o <= 32'h0000_0000;
      if (wb_adr_i[7:5] == 3'h0 && wb_idx < 3'h5)
        wb_dat_o <= {26'h0, sel_reg[wb_idx]};
      else if (wb_adr_i == ddid_pkg::OFS_CFG)
        wb_dat_o <= {28'h0, cfg_reg};
      else if (wb_adr_i == ddid_pkg::OFS_STATUS)
        wb_dat_o <= {10'h000, cmd_o};
      else if (wb_adr_i == ddid_pkg::OFS_STEP)
        wb_dat_o <= {16'h0, step_cnt_reg};
    end
  end

  // assertions
  a_coast_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    f_coast |=> cmd_o.coast) else $error("coast not issued");
  a_dc_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_reg[ddid_pkg::CFG_DC_TIME_NZ] |=> !cmd_o.dc_brake) else $error("dc brake not gated");
  a_fix_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    (f_coast || f_qstop) |=> !cmd_o.fixed_speed) else $error("fixed speed not blocked");
  a_slow_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cmd_o.catch_up && cmd_o.slow_down)) else $error("catch and slow together");
  a_step_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    !(step_up_o && step_dn_o)) else $error("two steps at once");
  a_rev_closed: assert property (@(posedge clk_i) disable iff (rst_i)
    closed && $stable(closed) |=> !cmd_o.reverse) else $error("reverse in closed loop");
  a_latch_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_any |=> !latch_run_reg) else $error("latched run kept after stop");
  a_run_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_any |=> !cmd_o.run) else $error("run during stop");
  a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  // quick stop follows its inverted input
  a_qstop_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    f_qstop |=> cmd_o.quick_stop) else $error("quick stop not issued");
  // ramp stop follows its inverted input
  a_stop_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    f_stop |=> cmd_o.ramp_stop) else $error("ramp stop not issued");
  // an unhalted start input runs the motor
  a_start_runs: assert property (@(posedge clk_i) disable iff (rst_i)
    (f_start && !halt_any) |=> cmd_o.run) else $error("start not obeyed");
  // zero brake voltage gates dc braking
  a_dc_volt: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_reg[ddid_pkg::CFG_DC_VOLT_NZ] |=> !cmd_o.dc_brake) else $error("dc volt gate");
  // latch sets only after a full-width pulse
  a_latch_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(latch_run_reg) |-> ($past(ls_cnt_reg) == CW'(MIN_PULSE - 1)))
    else $error("latched start on short pulse");
  // start-reversing in open loop with start low runs reversed
  a_srev_runs: assert property (@(posedge clk_i) disable iff (rst_i)
    (f_srev && !closed && !halt_any && !f_start) |=> (cmd_o.run && cmd_o.reverse))
    else $error("start-reversing not obeyed");
  // dc braking also blocks fixed speed
  a_fix_dc: assert property (@(posedge clk_i) disable iff (rst_i)
    dc_active |=> !cmd_o.fixed_speed) else $error("fixed speed during dc");
  // freeze commands follow their inputs
  a_frz_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    f_frz_r |=> cmd_o.freeze_ref) else $error("freeze ref not issued");
  a_frz_out: assert property (@(posedge clk_i) disable iff (rst_i)
    f_frz_o |=> cmd_o.freeze_out) else $error("freeze out not issued");
  // encoder needs matching codes on both pulse terminals
  a_enc_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_reg[ddid_pkg::PULSE_TERM_A] != sel_reg[ddid_pkg::PULSE_TERM_B]) |=> !cmd_o.enc_sel)
    else $error("encoder without pair");
  // a step only while a freeze mode is active
  a_step_frz: assert property (@(posedge clk_i) disable iff (rst_i)
    (step_up_o || step_dn_o) |-> $past(stp_active)) else $error("step without freeze");
  // preset index is msb then lsb
  a_preset_idx: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (cmd_o.preset_idx == {$past(f_pmsb), $past(f_plsb)}))
    else $error("preset index order");
  // the alarm pulse needs a qualifying edge
  a_alarm_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    alarm_clr_o |-> $past(f_rst_ev)) else $error("alarm reset without edge");
  // undefined codes leave the select unchanged
  a_sel_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_req && wb_we_i && wb_adr_i == ddid_pkg::OFS_SEL0
     && wb_dat_i[5:0] > ddid_pkg::FN_ENC_IN) |=> $stable(sel_reg[0]))
    else $error("undefined code stored");
endmodule : ddid_decoder
`default_nettype wire

// file: hw/ddid_pkg.sv
// ddid_pkg: constants, codes and carriers for the digital input decoder
// assumes a 40 MHz control clock and a classic wishbone register slave
package ddid_pkg;
  // terminals
  localparam int unsigned NUM_TERM = 5;           // five input terminals
  localparam int unsigned PULSE_TERM_A = 3;       // first pulse-capable terminal
  localparam int unsigned PULSE_TERM_B = 4;       // second pulse-capable terminal, the fifth
  // function-select codes
  localparam logic [5:0] FN_NONE      = 6'h00;
  localparam logic [5:0] FN_RESET     = 6'h01;
  localparam logic [5:0] FN_COAST_N   = 6'h02;
  localparam logic [5:0] FN_RUNOUT_CLR = 6'h03;   // runout_with_alarm_clear
  localparam logic [5:0] FN_QSTOP_N   = 6'h04;
  localparam logic [5:0] FN_DCHALT_N  = 6'h05;    // dc_injection_halt_low_active
  localparam logic [5:0] FN_STOP_N    = 6'h06;
  localparam logic [5:0] FN_START     = 6'h07;
  localparam logic [5:0] FN_LSTART    = 6'h08;
  localparam logic [5:0] FN_REV       = 6'h09;
  localparam logic [5:0] FN_START_REV = 6'h0A;
  localparam logic [5:0] FN_START_CW  = 6'h0B;
  localparam logic [5:0] FN_START_CCW = 6'h0C;
  localparam logic [5:0] FN_FIXSPD    = 6'h0D;    // fixed_speed_override
  localparam logic [5:0] FN_FRZ_REF   = 6'h0E;
  localparam logic [5:0] FN_FRZ_OUT   = 6'h0F;
  localparam logic [5:0] FN_SPD_UP    = 6'h10;
  localparam logic [5:0] FN_SPD_DN    = 6'h11;
  localparam logic [5:0] FN_CATCH     = 6'h13;
  localparam logic [5:0] FN_SLOW      = 6'h14;
  localparam logic [5:0] FN_RAMP2     = 6'h15;
  localparam logic [5:0] FN_PRE_LSB   = 6'h16;
  localparam logic [5:0] FN_PRE_MSB   = 6'h17;
  localparam logic [5:0] FN_PRE_ON    = 6'h18;
  localparam logic [5:0] FN_PSTOP_N   = 6'h1A;
  localparam logic [5:0] FN_PSTARTSTOP = 6'h1B;
  localparam logic [5:0] FN_PULSE_REF = 6'h1C;
  localparam logic [5:0] FN_PULSE_FB  = 6'h1D;
  localparam logic [5:0] FN_PULSE_IN  = 6'h1E;
  localparam logic [5:0] FN_SETUP_LSB = 6'h1F;
  localparam logic [5:0] FN_SETUP_MSB = 6'h20;
  localparam logic [5:0] FN_RST_START = 6'h21;
  localparam logic [5:0] FN_ENC_REF   = 6'h22;
  localparam logic [5:0] FN_ENC_FB    = 6'h23;
  localparam logic [5:0] FN_ENC_IN    = 6'h24;
  // reset values of the function selects per terminal
  localparam logic [5:0] SEL_RST_0 = 6'h07;
  localparam logic [5:0] SEL_RST_1 = 6'h09;
  localparam logic [5:0] SEL_RST_2 = 6'h03;
  localparam logic [5:0] SEL_RST_3 = 6'h0D;
  localparam logic [5:0] SEL_RST_4 = 6'h00;
  // register byte offsets
  localparam logic [7:0] OFS_SEL0   = 8'h00;      // selects at 0x00..0x10
  localparam logic [7:0] OFS_CFG    = 8'h14;      // configuration bits
  localparam logic [7:0] OFS_STATUS = 8'h18;      // command status, read only
  localparam logic [7:0] OFS_STEP   = 8'h1C;      // speed step counter, read only
  // cfg field positions
  localparam int unsigned CFG_CLOSED_LOOP = 0;    // process regulation closed loop
  localparam int unsigned CFG_PULSE_OUT   = 1;    // digital output is pulse output
  localparam int unsigned CFG_DC_TIME_NZ  = 2;    // dc brake time non-zero
  localparam int unsigned CFG_DC_VOLT_NZ  = 3;    // dc brake voltage non-zero
  localparam logic [3:0]  CFG_RST = 4'h0;
  // timing
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned MIN_PULSE_MS = 14;
  localparam int unsigned MIN_PULSE_CYC = (CLK_HZ / 1000) * MIN_PULSE_MS;
  // command outputs
  typedef struct packed {
    logic       coast;       // output stage off
    logic       quick_stop;  // quick stop ramp
    logic       dc_brake;    // dc injection braking
    logic       ramp_stop;   // ramp to standstill
    logic       run;         // run request
    logic       reverse;     // reverse direction
    logic       dir_cw_only; // clockwise only
    logic       dir_ccw_only;// anticlockwise only
    logic       fixed_speed; // fixed speed override
    logic       freeze_ref;  // hold reference
    logic       freeze_out;  // hold output frequency
    logic       ramp2;       // second ramp pair
    logic [1:0] preset_idx;  // preset index
    logic       preset_on;   // preset references active
    logic       catch_up;    // add percentage
    logic       slow_down;   // subtract percentage
    logic [1:0] setup_idx;   // setup index
    logic       pulse_ref;   // pulse reference source
    logic       pulse_fb;    // pulse feedback source
    logic       enc_sel;     // encoder pair selected
  } ddid_cmd_s;
endpackage : ddid_pkg

// file: sim/ddid_decoder_tb.sv
// ddid_decoder_tb: register and terminal tests of the input decoder
// assumes the switch model on the terminals and an 8-cycle pulse width
`timescale 1ns/1ps
`default_nettype none
module ddid_decoder_tb;
  logic               clk_i = 1'b0;  // 40 MHz clock
  logic               rst_i = 1'b1;  // sync reset
  logic [4:0]         want  = 5'h04; // terminal 2 high keeps coast off
  logic [4:0]         term;          // terminal levels
  logic               cyc   = 1'b0;  // bus cycle
  logic               stb   = 1'b0;  // bus strobe
  logic               we    = 1'b0;  // bus direction
  logic [7:0]         adr   = 8'h00; // bus address
  logic [31:0]        wdat  = 32'h0; // write data
  logic [31:0]        rdat;          // read data
  logic               ack;           // bus answer
  ddid_pkg::ddid_cmd_s cmd;          // decoded commands
  logic               aclr;          // alarm reset pulse
  logic [31:0]        rd;            // last read word
  int                 pulses;        // alarm pulses seen
  int                 ups;           // step up pulses seen
  int                 dns;           // step down pulses seen
  logic               su;            // step up pulse
  logic               sd;            // step down pulse
  logic [3:0]         sel   = 4'h0;  // byte selects
  ddid_pkg::ddid_cmd_s ex;           // expected command word
  int                 num_errors = 0;
  int                 compares = 0;
  always #12.5 clk_i = ~clk_i;
  ddid_switch_model sw (.clk_i(clk_i), .want_i(want), .term_o(term));
  ddid_decoder #(.MIN_PULSE(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .term_i(term),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cmd_o(cmd),
    .alarm_clr_o(aclr), .step_up_o(su), .step_dn_o(sd));
  // verdict and end of run
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // word comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic wishbone cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    if (ack !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t no bus answer", $time);
      wrap_up();
    end
  endtask : wb
  // move the switches, count alarm pulses while the decoder settles
  task automatic setp(input logic [4:0] v);
    pulses = 0;
    ups = 0;
    dns = 0;
    @(posedge clk_i);
    want <= v;
    repeat (10) begin
      @(posedge clk_i);
      if (aclr === 1'b1) pulses++;
      if (su === 1'b1) ups++;
      if (sd === 1'b1) dns++;
    end
  endtask : setp
  // main sequence
  initial begin
    logic [5:0] rs [5];
    rs = '{ddid_pkg::SEL_RST_0, ddid_pkg::SEL_RST_1, ddid_pkg::SEL_RST_2,
           ddid_pkg::SEL_RST_3, ddid_pkg::SEL_RST_4};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int t = 0; t < 5; t++) begin
      wb(1'b0, 8'(4 * t), 32'h0);
      chk(rd, {26'h0, rs[t]});
    end
    wb(1'b0, ddid_pkg::OFS_CFG, 32'h0);
    chk(rd, {28'h0, ddid_pkg::CFG_RST});
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, ddid_pkg::OFS_SEL0, 32'h12);
    wb(1'b0, ddid_pkg::OFS_SEL0, 32'h0);
    chk(rd, 32'h07);
    setp(5'h05);
    chk({31'h0, cmd.run}, 32'h1);
    ex = '0;
    ex.run = 1'b1;
    wb(1'b0, ddid_pkg::OFS_STATUS, 32'h0);
    chk(rd, {10'h000, ex});
    setp(5'h15);
    wb(1'b0, ddid_pkg::OFS_STATUS, 32'h0);
    chk(rd, {10'h000, ex});
    setp(5'h04);
    chk({31'h0, cmd.run}, 32'h0);
    wb(1'b1, ddid_pkg::OFS_SEL0, {26'h0, ddid_pkg::FN_RESET});
    setp(5'h05);
    chk(32'(pulses), 32'h1);
    setp(5'h01);
    chk(32'(pulses), 32'h1);
    chk({31'h0, cmd.coast}, 32'h1);
    wb(1'b1, ddid_pkg::OFS_SEL0, {26'h0, ddid_pkg::FN_COAST_N});
    setp(5'h04);
    chk({31'h0, cmd.coast}, 32'h1);
    wb(1'b1, ddid_pkg::OFS_SEL0, {26'h0, ddid_pkg::FN_DCHALT_N});
    setp(5'h04);
    chk({31'h0, cmd.dc_brake}, 32'h0);
    wb(1'b1, ddid_pkg::OFS_CFG, 32'h4);
    setp(5'h0C);
    chk({31'h0, cmd.dc_brake}, 32'h0);
    wb(1'b1, ddid_pkg::OFS_CFG, 32'hC);
    setp(5'h0C);
    chk({31'h0, cmd.dc_brake}, 32'h1);
    chk({31'h0, cmd.fixed_speed}, 32'h0);
    setp(5'h07);
    chk({31'h0, cmd.reverse}, 32'h1);
    wb(1'b1, ddid_pkg::OFS_CFG, 32'hD);
    setp(5'h07);
    chk({31'h0, cmd.reverse}, 32'h0);
    wb(1'b1, ddid_pkg::OFS_CFG, 32'h2);
    wb(1'b1, 8'h10, {26'h0, ddid_pkg::FN_PULSE_REF});
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, ddid_pkg::OFS_CFG, 32'h0);
    wb(1'b1, 8'h10, {26'h0, ddid_pkg::FN_PULSE_REF});
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, {26'h0, ddid_pkg::FN_PULSE_REF});
    setp(5'h04);
    wb(1'b1, 8'h00, {26'h0, ddid_pkg::FN_FRZ_REF});
    wb(1'b1, 8'h04, {26'h0, ddid_pkg::FN_SPD_UP});
    wb(1'b1, 8'h10, {26'h0, ddid_pkg::FN_SPD_DN});
    setp(5'h07);
    setp(5'h05);
    chk({ups[15:0], dns[15:0]}, 32'h0001_0000);
    wb(1'b0, ddid_pkg::OFS_STEP, 32'h0);
    chk(rd, 32'h1);
    setp(5'h17);
    setp(5'h05);
    chk({ups[15:0], dns[15:0]}, 32'h0000_0001);
    wb(1'b0, ddid_pkg::OFS_STEP, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h04, {26'h0, ddid_pkg::FN_STOP_N});
    setp(5'h06);
    wb(1'b1, 8'h00, {26'h0, ddid_pkg::FN_LSTART});
    setp(5'h07);
    setp(5'h06);
    chk({31'h0, cmd.run}, 32'h1);
    setp(5'h04);
    chk({30'h0, cmd.run, cmd.ramp_stop}, 32'h1);
    setp(5'h06);
    chk({31'h0, cmd.run}, 32'h0);
    wb(1'b1, 8'h04, {26'h0, ddid_pkg::FN_QSTOP_N});
    setp(5'h0C);
    chk({30'h0, cmd.quick_stop, cmd.fixed_speed}, 32'h2);
    setp(5'h0E);
    chk({30'h0, cmd.quick_stop, cmd.fixed_speed}, 32'h1);
    wrap_up();
  end
endmodule : ddid_decoder_tb
`default_nettype wire

// file: sim/ddid_switch_model.sv
// ddid_switch_model: external switches on the five input terminals
// assumes the bench asks for levels just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module ddid_switch_model (
  input  wire logic       clk_i,  // control clock, paces the switches
  input  wire logic [4:0] want_i, // wanted switch positions
  output logic      [4:0] term_o  // terminal levels
);
  // contacts settle one cycle after a request; the bench holds pulses long enough
  always_ff @(posedge clk_i) begin
    term_o <= want_i;
  end
endmodule : ddid_switch_model
`default_nettype wire
